// ==== serial_link_cfg.svh ====
/*
 * Constants for the serial link configuration register: offsets,
 * field positions, reset value.
 * Assumes inclusion by bare name from the design.
 */
`ifndef SERIAL_LINK_CFG_SVH
`define SERIAL_LINK_CFG_SVH

// ==========================================================
// Register map
`define SLC_CONFIG_ADDR 8'h60
`define SLC_STATUS_ADDR 8'h64
`define SLC_CONFIG_RESET 8'h7d

// ==========================================================
// Field positions
`define SLC_SCR_BIT 7
`define SLC_K_HI 6
`define SLC_K_LO 2
`define SLC_L_BIT 1
`define SLC_EN_BIT 0
`define SLC_K_MIN_CODE 5'h08

`endif

// ==== serial_link_pkg.sv ====
/*
 * Types for the serial link configuration block.
 * Needs no include file; only the design includes serial_link_cfg.svh.
 */
package serial_link_pkg;
    typedef enum logic [2:0] {
        LINK_PATTERN = 3'b001,
        LINK_SYNC = 3'b010,
        LINK_RUN = 3'b100
    } link_state_t;
endpackage

// ==== serial_link_config_ctrl.sv ====
/*
 * Link configuration register on a classic Wishbone slave, with the
 * shadow settings applied to the lane datapath and the link mode state.
 * Assumes one clock, synchronous reset, and a lane datapath that
 * obeys the mode and lane enable outputs.
 */
// Operation
// - Bit 7 enables lane scrambling, reset off
// - Bits 6:2 hold frames per multiframe less one
// - Bit 1 holds lanes per channel less one
// - Single lane uses lane zero only
// - Link enable set runs sync and data
// - Link enable clear sends alternating test pattern
// - Register at 0x60, resets to 0x7d
`timescale 1ns/1ps
`include "serial_link_cfg.svh"

module serial_link_config_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic sync_done_i,
    output logic scrambler_on_o,
    output logic [4:0] frames_per_multiframe_less_one_o,
    output logic lanes_per_channel_less_one_o,
    output logic link_sync_o,
    output logic link_run_o,
    output logic test_pattern_o,
    output logic [1:0] chan_a_lane_on_o,
    output logic [1:0] chan_b_lane_on_o,
    output serial_link_pkg::link_state_t state_o
);
    import serial_link_pkg::*;

    // ==========================================================
    // Bus decode
    logic [7:0] config_q;
    logic [7:0] config_d;
    logic [7:0] applied_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [31:0] rd_data;
    logic [1:0] sync_pipe_q;
    logic k_reserved;
    link_state_t state_q;
    link_state_t state_d;

    wire req = cyc_i & stb_i & ~ack_q;
    wire hit_config = (adr_i == `SLC_CONFIG_ADDR);
    wire hit_status = (adr_i == `SLC_STATUS_ADDR);
    wire wr_config = req & we_i & hit_config & sel_i[0];
    wire en_rise = config_d[`SLC_EN_BIT] & ~config_q[`SLC_EN_BIT];

    assign config_d = wr_config ? dat_i[7:0] : config_q;
    // Reserved K codes are flagged only; software owns the range
    assign k_reserved = applied_q[`SLC_K_HI:`SLC_K_LO] < `SLC_K_MIN_CODE;
    assign rd_data = hit_config ? {24'h0, config_q} :
                     hit_status ? {24'h0, 4'h0, k_reserved, state_q} : 32'h0;

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            config_q <= `SLC_CONFIG_RESET;
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            config_q <= config_d;
            ack_q <= req;
            dat_q <= req ? rd_data : dat_q;
        end
    end

    // Shadow copy: live edits while running never reach the lanes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            applied_q <= `SLC_CONFIG_RESET;
        end else if (en_rise) begin
            applied_q <= config_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_pipe_q <= 2'b00;
        end else begin
            sync_pipe_q <= {sync_pipe_q[0], sync_done_i};
        end
    end

    // ==========================================================
    // Link mode
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            LINK_PATTERN: begin
                if (en_rise) begin
                    state_d = LINK_SYNC;
                end
            end
            LINK_SYNC: begin
                if (!config_q[`SLC_EN_BIT]) begin
                    state_d = LINK_PATTERN;
                end else if (sync_pipe_q[1]) begin
                    state_d = LINK_RUN;
                end
            end
            LINK_RUN: begin
                if (!config_q[`SLC_EN_BIT]) begin
                    state_d = LINK_PATTERN;
                end
            end
            default: state_d = LINK_PATTERN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= LINK_SYNC;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign state_o = state_q;
    assign scrambler_on_o = applied_q[`SLC_SCR_BIT];
    assign frames_per_multiframe_less_one_o = applied_q[`SLC_K_HI:`SLC_K_LO];
    assign lanes_per_channel_less_one_o = applied_q[`SLC_L_BIT];
    assign chan_a_lane_on_o = {applied_q[`SLC_L_BIT], 1'b1};
    assign chan_b_lane_on_o = {applied_q[`SLC_L_BIT], 1'b1};
    assign link_sync_o = state_q == LINK_SYNC;
    assign link_run_o = state_q == LINK_RUN;
    assign test_pattern_o = state_q == LINK_PATTERN;
endmodule

// ==== slc_properties.sv ====
/* Port assertions for the link configuration register.
   Assumes one clock and the bind at the foot. */
`timescale 1ns/1ps
module slc_properties (
    input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sel_i0,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i, dat_o,
    input wire logic scrambler_on_o, lanes_per_channel_less_one_o,
    input wire logic [4:0] frames_per_multiframe_less_one_o,
    input wire logic link_sync_o, link_run_o, test_pattern_o, sync_done_i,
    input wire logic [1:0] chan_a_lane_on_o, chan_b_lane_on_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic take = cyc_i && stb_i && !ack_o;
    wire logic [6:0] applied = {scrambler_on_o, frames_per_multiframe_less_one_o,
        lanes_per_channel_less_one_o};
    a_ack_next:
    assert property (take |=> ack_o) else $error("ack late");
    a_ack_single:
    assert property (ack_o |=> !ack_o) else $error("ack held");
    a_upper_zero:
    assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bytes set");
    a_clear_pattern:
    assert property (take && we_i && adr_i == 8'h60 && sel_i0 && !dat_i[0]
        |-> ##[1:2] test_pattern_o) else $error("no test pattern");
    a_lane_map:
    assert property (chan_a_lane_on_o == {lanes_per_channel_less_one_o, 1'b1}
        && chan_b_lane_on_o == chan_a_lane_on_o) else $error("lane map");
    a_run_frozen:
    assert property (link_run_o |=> $stable(applied)) else $error("fields moved");
    a_sync_run:
    assert property (link_sync_o && sync_done_i |-> ##[1:4] (link_run_o || test_pattern_o))
        else $error("no run");
    a_one_mode:
    assert property ($onehot({link_sync_o, link_run_o, test_pattern_o})) else $error("mode");
endmodule
bind serial_link_config_ctrl slc_properties slc_properties_i (.sel_i0(sel_i[0]), .*);

// ==== link_receiver_model.sv ====
/* Receiver model: reports sync LAG cycles after the link asks.
   Assumes the design's clock. */
`timescale 1ns/1ps
module link_receiver_model #(parameter int LAG = 5) (
    input wire logic clk_i,
    input wire logic link_sync_i,
    input wire logic link_run_i,
    output logic sync_done_o = 1'b0
);
    int n = 0;
    // Sync holds only while the link runs
    always @(posedge clk_i) begin
        n <= link_sync_i ? n + 1 : 0;
        sync_done_o <= (link_sync_i && n >= LAG) || (link_run_i && sync_done_o);
    end
endmodule

// ==== serial_link_config_ctrl_tb.sv ====
/* Bench for the link configuration register.
   Assumes the receiver model and the bound checker. */
`timescale 1ns/1ps
module serial_link_config_ctrl_tb;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0] adr_i = 8'h0;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, r;
    logic ack_o, sd, scr, ln, ls, lr, pat;
    logic [4:0] k;
    logic [1:0] la, lb;
    int n_errors = 0, comparisons = 0;
    // Write address, write data, read address, expected read
    logic [31:0] rows [5] = '{32'h607c607c, 32'h60a260a2, 32'h70557000, 32'h61ff60a2,
        32'h64ff6401};
    serial_link_config_ctrl serial_link_config_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sync_done_i(sd), .scrambler_on_o(scr),
        .frames_per_multiframe_less_one_o(k), .lanes_per_channel_less_one_o(ln),
        .link_sync_o(ls), .link_run_o(lr), .test_pattern_o(pat), .chan_a_lane_on_o(la),
        .chan_b_lane_on_o(lb), .state_o());
    link_receiver_model link_receiver_model_i (.clk_i(clk_i), .link_sync_i(ls),
        .link_run_i(lr), .sync_done_o(sd));
    task automatic chk(input logic [31:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic complete_run;
        $display("%0d mismatches in %0d comparisons", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial forever #50 clk_i = ~clk_i;
    initial begin
        repeat (2000) @(posedge clk_i);
        n_errors++;
        complete_run;
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        bus(0, 8'h60, 8'h0);
        chk(r, 32'h7d, "reset value");
        chk({scr, k, ln, pat, la}, {8'h7c, 2'b01}, "reset fields");
        for (int i = 0; i < 5; i++) begin
            bus(1, rows[i][31:24], rows[i][23:16]);
            bus(0, rows[i][15:8], 8'h0);
            chk(r, {24'h0, rows[i][7:0]}, "readback");
        end
        $display("table done");
        chk({pat, scr, k}, 7'h5f, "held fields");
        bus(1, 8'h60, 8'ha3);
        chk({scr, k, ln, la, lb}, 11'h51f, "applied");
        repeat (15) @(posedge clk_i);
        chk(lr, 1, "run");
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        bus(0, 8'h60, 8'h0);
        chk(r, 32'h7d, "value after reset");
        $display("hand tests done");
        complete_run;
    end
endmodule
